// ### hdl/eth_stats_counters.v
// read-to-clear ethernet receive and transmit statistics counter bank
//
// Function
// - count filtered short frames with bad crc
// - runts under 25 bytes may go uncounted
// - count filtered oversize frames with good crc
// - count filtered oversize frames with bad crc
// - length spans destination address through crc
// - receive counters frozen while receiver disabled
// - sum octets of every received frame that passed the filter or is broadcast
// - rejected broadcasts still count in receive totals
// - octet totals are 64-bit, two words
// - sum transmitted octets except collision aborts
// - transmit counters frozen while transmitter disabled
// - count every received frame that passed the filter or is broadcast in total
// - disconnect-cut frames may count in total
// - count every completed transmit except collision aborts in total
// - 64-byte bin excludes flow control, aborts
// - bins 65-127, 128-255, 256-511 exclude aborts
// - 32-bit counters, reset zero, clear on read
`timescale 1ns/10ps
`include "eth_stats_regs.vh"

module eth_stats_counters #(
  parameter ADDR_W = 16,
  parameter LEN_W  = 16
) (
  input  wire              CLK_SYS_IN,
  input  wire              RST_IN,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] AWADDR_IN,
  input  wire              AWVALID_IN,
  output wire              AWREADY_OUT,
  // axi4-lite write data
  input  wire [31:0]       WDATA_IN,
  input  wire [3:0]        WSTRB_IN,
  input  wire              WVALID_IN,
  output wire              WREADY_OUT,
  // axi4-lite write response
  output wire [1:0]        BRESP_OUT,
  output wire              BVALID_OUT,
  input  wire              BREADY_IN,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] ARADDR_IN,
  input  wire              ARVALID_IN,
  output wire              ARREADY_OUT,
  // axi4-lite read data
  output wire [31:0]       RDATA_OUT,
  output wire [1:0]        RRESP_OUT,
  output wire              RVALID_OUT,
  input  wire              RREADY_IN,
  // receive frame report, one pulse per frame end
  input  wire              RX_FRAME_DONE_IN,
  input  wire [LEN_W-1:0]  RX_FRAME_LEN_IN,
  input  wire              RX_CRC_OK_IN,
  input  wire              RX_ADDR_PASS_IN,
  input  wire              RX_BROADCAST_IN,
  // transmit frame report, one pulse per frame end
  input  wire              TX_FRAME_DONE_IN,
  input  wire [LEN_W-1:0]  TX_FRAME_LEN_IN,
  input  wire              TX_FLOW_CTRL_IN,
  input  wire              TX_COLL_ABORT_IN,
  // enable bits, for the mac datapaths
  output wire              RX_ENABLE_OUT,
  output wire              TX_ENABLE_OUT
);

  // counter slots of the 32-bit bank
  localparam NCNT     = 9;
  localparam I_FRAG   = 0;
  localparam I_OVER   = 1;
  localparam I_JAB    = 2;
  localparam I_RXPKT  = 3;
  localparam I_TXPKT  = 4;
  localparam I_B64    = 5;
  localparam I_B127   = 6;
  localparam I_B255   = 7;
  localparam I_B511   = 8;

  // bus state
  reg              awready_q;
  reg              wready_q;
  reg              bvalid_q;
  reg [1:0]        bresp_q;
  reg              arready_q;
  reg              rvalid_q;
  reg [1:0]        rresp_q;
  reg [31:0]       rdata_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0]       wdata_q;
  reg [3:0]        wstrb_q;

  // control state
  reg [1:0]        ctrl_q;
  reg [LEN_W-1:0]  max_len_q;

  // counters
  reg [31:0]       cnt_q [0:NCNT-1];
  reg [63:0]       rx_oct_q;
  reg [63:0]       tx_oct_q;
  reg [31:0]       rx_hi_shadow_q;
  reg [31:0]       tx_hi_shadow_q;

  // decode helpers
  wire             ar_take;
  wire             aw_take;
  wire             w_take;
  wire             wr_go;
  wire             rx_en;
  wire             tx_en;
  wire             rx_ev;
  wire             rx_tot_ev;
  wire             tx_ev;
  wire             rx_long;
  wire             rx_short;
  wire [NCNT-1:0]  inc;
  reg  [NCNT-1:0]  clr;
  reg  [31:0]      rd_data;
  reg              rd_hit;
  wire             rd_rx_lo;
  wire             rd_rx_hi;
  wire             rd_tx_lo;
  wire             rd_tx_hi;
  wire [63:0]      rx_add;
  wire [63:0]      tx_add;

  assign AWREADY_OUT   = awready_q;
  assign WREADY_OUT    = wready_q;
  assign BVALID_OUT    = bvalid_q;
  assign BRESP_OUT     = bresp_q;
  assign ARREADY_OUT   = arready_q;
  assign RVALID_OUT    = rvalid_q;
  assign RRESP_OUT     = rresp_q;
  assign RDATA_OUT     = rdata_q;
  assign RX_ENABLE_OUT = ctrl_q[`RECEIVER_ENABLE_BIT];
  assign TX_ENABLE_OUT = ctrl_q[`TRANSMITTER_ENABLE_BIT];

  // handshakes; ready drops after a take so only one access of each kind is open
  assign ar_take = ARVALID_IN & arready_q;
  assign aw_take = AWVALID_IN & awready_q;
  assign w_take  = WVALID_IN & wready_q;
  assign wr_go   = ~awready_q & ~wready_q & ~bvalid_q;

  assign rx_en = ctrl_q[`RECEIVER_ENABLE_BIT];
  assign tx_en = ctrl_q[`TRANSMITTER_ENABLE_BIT];

  // the mac reports a length that already spans destination address through crc
  assign rx_ev     = RX_FRAME_DONE_IN & rx_en;
  assign rx_long   = RX_FRAME_LEN_IN > max_len_q;
  assign rx_short  = RX_FRAME_LEN_IN < `MIN_FRAME_BYTES;
  // broadcasts count in the totals even when the filter threw them out
  assign rx_tot_ev = rx_ev & (RX_ADDR_PASS_IN | RX_BROADCAST_IN);
  // collision aborts never reach any transmit counter
  assign tx_ev     = TX_FRAME_DONE_IN & tx_en & ~TX_COLL_ABORT_IN;

  // per-counter increment qualifiers
  assign inc[I_FRAG]  = rx_ev & RX_ADDR_PASS_IN & rx_short & ~RX_CRC_OK_IN;
  assign inc[I_OVER]  = rx_ev & RX_ADDR_PASS_IN & rx_long & RX_CRC_OK_IN;
  assign inc[I_JAB]   = rx_ev & RX_ADDR_PASS_IN & rx_long & ~RX_CRC_OK_IN;
  // any length, error or type, including runts and disconnect-cut frames
  assign inc[I_RXPKT] = rx_tot_ev;
  assign inc[I_TXPKT] = tx_ev;
  assign inc[I_B64]   = tx_ev & ~TX_FLOW_CTRL_IN
                        & (TX_FRAME_LEN_IN == `MIN_FRAME_BYTES);
  assign inc[I_B127]  = tx_ev & (TX_FRAME_LEN_IN > `MIN_FRAME_BYTES)
                        & (TX_FRAME_LEN_IN <= `BIN_127_TOP);
  assign inc[I_B255]  = tx_ev & (TX_FRAME_LEN_IN > `BIN_127_TOP)
                        & (TX_FRAME_LEN_IN <= `BIN_255_TOP);
  assign inc[I_B511]  = tx_ev & (TX_FRAME_LEN_IN > `BIN_255_TOP)
                        & (TX_FRAME_LEN_IN <= `BIN_511_TOP);

  // octet increments, zero when the frame does not qualify
  assign rx_add = rx_tot_ev ? {{(64-LEN_W){1'b0}}, RX_FRAME_LEN_IN} : 64'h0;
  assign tx_add = tx_ev ? {{(64-LEN_W){1'b0}}, TX_FRAME_LEN_IN} : 64'h0;

  // octet word selects, only meaningful while a read address is taken
  assign rd_rx_lo = ar_take & (ARADDR_IN[15:2] == `RX_TOTAL_OCTETS_LOW_OFS >> 2);
  assign rd_rx_hi = ar_take & (ARADDR_IN[15:2] == `RX_TOTAL_OCTETS_HIGH_OFS >> 2);
  assign rd_tx_lo = ar_take & (ARADDR_IN[15:2] == `TX_TOTAL_OCTETS_LOW_OFS >> 2);
  assign rd_tx_hi = ar_take & (ARADDR_IN[15:2] == `TX_TOTAL_OCTETS_HIGH_OFS >> 2);

  // read mux and clear strobes; the clear happens on the address take
  always @* begin
    rd_data = `COUNTER_RESET;
    rd_hit  = 1'b1;
    clr     = {NCNT{1'b0}};
    case (ARADDR_IN[15:2])
      `RX_FRAGMENT_COUNT_OFS >> 2: begin
        rd_data     = cnt_q[I_FRAG];
        clr[I_FRAG] = ar_take;
      end
      `RX_OVERSIZE_COUNT_OFS >> 2: begin
        rd_data     = cnt_q[I_OVER];
        clr[I_OVER] = ar_take;
      end
      `RX_JABBER_COUNT_OFS >> 2: begin
        rd_data    = cnt_q[I_JAB];
        clr[I_JAB] = ar_take;
      end
      `RX_TOTAL_OCTETS_LOW_OFS >> 2: begin
        rd_data = rx_oct_q[31:0];
      end
      `RX_TOTAL_OCTETS_HIGH_OFS >> 2: begin
        rd_data = rx_hi_shadow_q;
      end
      `TX_TOTAL_OCTETS_LOW_OFS >> 2: begin
        rd_data = tx_oct_q[31:0];
      end
      `TX_TOTAL_OCTETS_HIGH_OFS >> 2: begin
        rd_data = tx_hi_shadow_q;
      end
      `RX_TOTAL_PACKETS_OFS >> 2: begin
        rd_data      = cnt_q[I_RXPKT];
        clr[I_RXPKT] = ar_take;
      end
      `TX_TOTAL_PACKETS_OFS >> 2: begin
        rd_data      = cnt_q[I_TXPKT];
        clr[I_TXPKT] = ar_take;
      end
      `TX_BIN_64_BYTES_OFS >> 2: begin
        rd_data    = cnt_q[I_B64];
        clr[I_B64] = ar_take;
      end
      `TX_BIN_65_TO_127_OFS >> 2: begin
        rd_data     = cnt_q[I_B127];
        clr[I_B127] = ar_take;
      end
      `TX_BIN_128_TO_255_OFS >> 2: begin
        rd_data     = cnt_q[I_B255];
        clr[I_B255] = ar_take;
      end
      `TX_BIN_256_TO_511_OFS >> 2: begin
        rd_data     = cnt_q[I_B511];
        clr[I_B511] = ar_take;
      end
      `STATS_CONTROL_OFS >> 2: begin
        rd_data = {30'h0, ctrl_q};
      end
      `MAX_FRAME_SIZE_OFS >> 2: begin
        rd_data = {{(32-LEN_W){1'b0}}, max_len_q};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // 32-bit counter bank; a clear restarts from zero plus this cycle's event
  genvar g;
  generate
    for (g = 0; g < NCNT; g = g + 1) begin : g_cnt
      always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
          cnt_q[g] <= `COUNTER_RESET;
        end else if (clr[g]) begin
          cnt_q[g] <= {31'h0, inc[g]};
        end else begin
          cnt_q[g] <= cnt_q[g] + {31'h0, inc[g]};
        end
      end
    end
  endgenerate

  // receive octet total, 64 bits seen as two words
  // reading the low word snapshots the high word and restarts the whole total,
  // so a carry between the two reads cannot tear the pair
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_oct_q       <= 64'h0;
      rx_hi_shadow_q <= `COUNTER_RESET;
    end else if (rd_rx_lo) begin
      rx_oct_q       <= rx_add;
      rx_hi_shadow_q <= rx_oct_q[63:32];
    end else begin
      rx_oct_q <= rx_oct_q + rx_add;
      if (rd_rx_hi) begin
        rx_hi_shadow_q <= `COUNTER_RESET;
      end
    end
  end

  // transmit octet total, same pairing as the receive side
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_oct_q       <= 64'h0;
      tx_hi_shadow_q <= `COUNTER_RESET;
    end else if (rd_tx_lo) begin
      tx_oct_q       <= tx_add;
      tx_hi_shadow_q <= tx_oct_q[63:32];
    end else begin
      tx_oct_q <= tx_oct_q + tx_add;
      if (rd_tx_hi) begin
        tx_hi_shadow_q <= `COUNTER_RESET;
      end
    end
  end

  // read channel: answer one cycle after the address take
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      rdata_q   <= rd_data;
    end else if (rvalid_q & RREADY_IN) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // write address and data are taken in either order and held until both are in
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= {ADDR_W{1'b0}};
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (aw_take) begin
        awready_q <= 1'b0;
        awaddr_q  <= AWADDR_IN;
      end
      if (w_take) begin
        wready_q <= 1'b0;
        wdata_q  <= WDATA_IN;
        wstrb_q  <= WSTRB_IN;
      end
      if (bvalid_q & BREADY_IN) begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // write commit and response; counters ignore writes but answer okay
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      ctrl_q    <= `CONTROL_RESET;
      max_len_q <= `MAX_FRAME_SIZE_RESET;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= `RESP_OKAY;
      case (awaddr_q[15:2])
        `STATS_CONTROL_OFS >> 2: begin
          if (wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
          end
        end
        `MAX_FRAME_SIZE_OFS >> 2: begin
          if (wstrb_q[0]) begin
            max_len_q[7:0] <= wdata_q[7:0];
          end
          if (wstrb_q[1]) begin
            max_len_q[15:8] <= wdata_q[15:8];
          end
        end
        `RX_FRAGMENT_COUNT_OFS >> 2,
        `RX_OVERSIZE_COUNT_OFS >> 2,
        `RX_JABBER_COUNT_OFS >> 2,
        `RX_TOTAL_OCTETS_LOW_OFS >> 2,
        `RX_TOTAL_OCTETS_HIGH_OFS >> 2,
        `TX_TOTAL_OCTETS_LOW_OFS >> 2,
        `TX_TOTAL_OCTETS_HIGH_OFS >> 2,
        `RX_TOTAL_PACKETS_OFS >> 2,
        `TX_TOTAL_PACKETS_OFS >> 2,
        `TX_BIN_64_BYTES_OFS >> 2,
        `TX_BIN_65_TO_127_OFS >> 2,
        `TX_BIN_128_TO_255_OFS >> 2,
        `TX_BIN_256_TO_511_OFS >> 2: begin
          bresp_q <= `RESP_OKAY;
        end
        default: begin
          bresp_q <= `RESP_SLVERR;
        end
      endcase
    end else if (bvalid_q & BREADY_IN) begin
      bvalid_q <= 1'b0;
    end
  end

endmodule

// ### hdl/eth_stats_regs.vh
// register map, field positions and reset values of the statistics counter bank
`ifndef ETH_STATS_REGS_VH
`define ETH_STATS_REGS_VH

// counter offsets (byte addresses)
`define RX_FRAGMENT_COUNT_OFS    16'h40A8
`define RX_OVERSIZE_COUNT_OFS    16'h40AC
`define RX_JABBER_COUNT_OFS      16'h40B0
`define RX_TOTAL_OCTETS_LOW_OFS  16'h40C0
`define RX_TOTAL_OCTETS_HIGH_OFS 16'h40C4
`define TX_TOTAL_OCTETS_LOW_OFS  16'h40C8
`define TX_TOTAL_OCTETS_HIGH_OFS 16'h40CC
`define RX_TOTAL_PACKETS_OFS     16'h40D0
`define TX_TOTAL_PACKETS_OFS     16'h40D4
`define TX_BIN_64_BYTES_OFS      16'h40D8
`define TX_BIN_65_TO_127_OFS     16'h40DC
`define TX_BIN_128_TO_255_OFS    16'h40E0
`define TX_BIN_256_TO_511_OFS    16'h40E4

// local control registers
`define STATS_CONTROL_OFS        16'h4200
`define MAX_FRAME_SIZE_OFS       16'h4204

// control register fields
`define RECEIVER_ENABLE_BIT      0
`define TRANSMITTER_ENABLE_BIT   1

// reset values
`define COUNTER_RESET            32'h0000_0000
`define CONTROL_RESET            2'h0
`define MAX_FRAME_SIZE_RESET     16'h05F2

// frame length limits, bytes from destination address through crc
`define MIN_FRAME_BYTES          16'h0040
`define BIN_127_TOP              16'h007F
`define BIN_255_TOP              16'h00FF
`define BIN_511_TOP              16'h01FF

// axi response codes
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

// ### testbench/eth_stats_properties.sv
// concurrent checks on the register port of the statistics counter bank
`timescale 1ns/10ps
module eth_stats_properties #(
  parameter ADDR_W = 16
) (
  input wire              CLK_SYS_IN,
  input wire              RST_IN,
  input wire              AWVALID_IN,
  input wire              AWREADY_OUT,
  input wire              WVALID_IN,
  input wire              WREADY_OUT,
  input wire [1:0]        BRESP_OUT,
  input wire              BVALID_OUT,
  input wire              BREADY_IN,
  input wire [ADDR_W-1:0] ARADDR_IN,
  input wire              ARVALID_IN,
  input wire              ARREADY_OUT,
  input wire [31:0]       RDATA_OUT,
  input wire [1:0]        RRESP_OUT,
  input wire              RVALID_OUT,
  input wire              RREADY_IN,
  input wire              RX_ENABLE_OUT,
  input wire              TX_ENABLE_OUT
);
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);

  // a taken read is answered on the next edge and blocks further reads
  read_answer_a:
    assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT && !ARREADY_OUT)
    else $error("read not answered one cycle after address");
  read_hold_a:
    assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read data dropped before handshake");
  read_release_a:
    assert property (RVALID_OUT && RREADY_IN |=> !RVALID_OUT && ARREADY_OUT)
    else $error("read channel not released after handshake");
  one_read_a:
    assert property (RVALID_OUT |-> !ARREADY_OUT)
    else $error("second read accepted while one is pending");
  // space below the bank holds nothing, so it must be refused with zero data
  low_space_a:
    assert property (ARVALID_IN && ARREADY_OUT && ARADDR_IN < 16'h40A8
                     |=> RRESP_OUT == 2'h2 && RDATA_OUT == 32'h0)
    else $error("unmapped read not refused");
  write_answer_a:
    assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT
                     |-> ##[1:2] BVALID_OUT)
    else $error("write response late");
  write_hold_a:
    assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write response dropped before handshake");
  // enables move only as the tail of a write, never on their own
  enable_write_a:
    assert property ($changed({RX_ENABLE_OUT, TX_ENABLE_OUT}) |-> !$past(AWREADY_OUT))
    else $error("enable changed without a write");
endmodule

bind eth_stats_counters eth_stats_properties #(.ADDR_W(ADDR_W)) eth_stats_properties_i (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .AWVALID_IN(AWVALID_IN),
  .AWREADY_OUT(AWREADY_OUT), .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT),
  .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN),
  .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
  .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT),
  .RREADY_IN(RREADY_IN), .RX_ENABLE_OUT(RX_ENABLE_OUT), .TX_ENABLE_OUT(TX_ENABLE_OUT));

// ### testbench/testbench.sv
// self-checking bench for the statistics counter bank
`timescale 1ns/10ps
`include "eth_stats_regs.vh"
module testbench;
  reg         clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
  reg  [15:0] awaddr, araddr, rx_len, tx_len;
  reg  [31:0] wdata, d;
  reg  [1:0]  r;
  reg         rx_done, rx_crc, rx_pass, rx_bc, tx_done, tx_flow, tx_ab;
  wire        awready, wready, bvalid, arready, rvalid, rx_en, tx_en;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  int         errors = 0;
  int         checked = 0;
  // receive table: length, crc good, passed filter, broadcast
  reg  [18:0] rxt [0:7] = '{{16'h003F, 3'h2}, {16'h0040, 3'h2}, {16'h05F3, 3'h6},
    {16'h05F2, 3'h6}, {16'h0640, 3'h2}, {16'h0014, 3'h2}, {16'h0064, 3'h5}, {16'h0064, 3'h4}};
  // transmit table: length, flow control, collision abort
  reg  [17:0] txt [0:9] = '{{16'h0040, 2'h2}, {16'h0040, 2'h0}, {16'h0041, 2'h0},
    {16'h007F, 2'h0}, {16'h0080, 2'h0}, {16'h00FF, 2'h0}, {16'h0100, 2'h0},
    {16'h01FF, 2'h0}, {16'h0200, 2'h0}, {16'h0064, 2'h1}};

  eth_stats_counters eth_stats_counters_i (
    .CLK_SYS_IN(clk_sys), .RST_IN(rst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'hF), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .RX_FRAME_DONE_IN(rx_done), .RX_FRAME_LEN_IN(rx_len), .RX_CRC_OK_IN(rx_crc),
    .RX_ADDR_PASS_IN(rx_pass), .RX_BROADCAST_IN(rx_bc), .TX_FRAME_DONE_IN(tx_done),
    .TX_FRAME_LEN_IN(tx_len), .TX_FLOW_CTRL_IN(tx_flow), .TX_COLL_ABORT_IN(tx_ab),
    .RX_ENABLE_OUT(rx_en), .TX_ENABLE_OUT(tx_en));

  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bready rises only once bvalid is seen, so the held response is exercised too
  task automatic wr(input [15:0] a, input [31:0] v, output [1:0] rs);
    {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'h3};
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'b0;
  endtask

  // ev launches one receive frame on the very edge that takes the read
  task automatic rd(input [15:0] a, input ev, output [31:0] v, output [1:0] rs);
    {araddr, arvalid} <= {a, 1'b1};
    if (ev) {rx_done, rx_len, rx_crc, rx_pass, rx_bc} <= {1'b1, 16'h000A, 3'h6};
    do begin
      @(posedge clk_sys);
      if (ev) rx_done <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    {v, rs} = {rdata, rresp};
    rready <= 1'b0;
  endtask

  task automatic rdc(input string nm, input [15:0] a, input [31:0] exp);
    reg [31:0] v;
    reg [1:0]  s;
    rd(a, 1'b0, v, s);
    chk(nm, v, exp);
  endtask

  // frame reports are left raised so back-to-back frames need no gap
  task automatic rxf(input [15:0] n, input c, input p, input b);
    {rx_done, rx_len, rx_crc, rx_pass, rx_bc} <= {1'b1, n, c, p, b};
    @(posedge clk_sys);
  endtask

  task automatic txf(input [15:0] n, input f, input ab);
    {tx_done, tx_len, tx_flow, tx_ab} <= {1'b1, n, f, ab};
    @(posedge clk_sys);
  endtask

  task automatic quiet;
    {rx_done, tx_done} <= 2'h0;
    @(posedge clk_sys);
  endtask

  // watchdog sized for about 66000 cycles of tests
  initial begin
    repeat (80000) @(posedge clk_sys);
    errors++;
    complete_run;
  end

  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid, rx_done, rx_len, rx_crc} = '0;
    {rx_pass, rx_bc, tx_done, tx_len, tx_flow, tx_ab} = '0;
    {rst, bready, rready} = 3'h4;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 'h40A8; a <= 'h40E4; a += 4) begin
      rd(a[15:0], 1'b0, d, r);
      chk("reset value", d, 32'h0);
      chk("resp", {30'h0, r}, (a > 'h40B0 && a < 'h40C0) ? 32'h2 : 32'h0);
    end
    rd(16'h0000, 1'b0, d, r);
    chk("low space resp", {30'h0, r}, 32'h2);
    rdc("max frame size", `MAX_FRAME_SIZE_OFS, 32'h5F2);
    $display("test reset values done");
    wr(`STATS_CONTROL_OFS, 32'h3, r);
    chk("enables", {30'h0, tx_en, rx_en}, 32'h3);
    foreach (rxt[i]) rxf(rxt[i][18:3], rxt[i][2], rxt[i][1], rxt[i][0]);
    quiet;
    wr(16'h40AC, 32'hFFFFFFFF, r);
    chk("counter write resp", {30'h0, r}, 32'h0);
    wr(16'h0000, 32'h1, r);
    chk("unmapped write resp", {30'h0, r}, 32'h2);
    rdc("fragments", 16'h40A8, 32'h2);
    rdc("oversize", 16'h40AC, 32'h1);
    rdc("jabber", 16'h40B0, 32'h1);
    rdc("rx octets low", 16'h40C0, 32'h131C);
    rdc("rx octets high", 16'h40C4, 32'h0);
    rdc("rx packets", 16'h40D0, 32'h7);
    rdc("fragments cleared", 16'h40A8, 32'h0);
    $display("test receive counts done");
    foreach (txt[i]) txf(txt[i][17:2], txt[i][1], txt[i][0]);
    quiet;
    rdc("tx octets low", 16'h40C8, 32'h7BE);
    rdc("tx octets high", 16'h40CC, 32'h0);
    rdc("tx packets", 16'h40D4, 32'h9);
    rdc("bin 64", 16'h40D8, 32'h1);
    rdc("bin 127", 16'h40DC, 32'h2);
    rdc("bin 255", 16'h40E0, 32'h2);
    rdc("bin 511", 16'h40E4, 32'h2);
    $display("test transmit counts done");
    repeat (3) rxf(16'h000A, 1'b1, 1'b1, 1'b0);
    quiet;
    rd(16'h40D0, 1'b1, d, r);
    chk("packets at clear", d, 32'h3);
    rdc("packet kept", 16'h40D0, 32'h1);
    rdc("octets kept", 16'h40C0, 32'h28);
    rdc("octets kept high", 16'h40C4, 32'h0);
    $display("test read clear collision done");
    // rejected broadcasts of 65535 bytes carry the low word over
    repeat (65538) rxf(16'hFFFF, 1'b1, 1'b0, 1'b1);
    quiet;
    rdc("wide low", 16'h40C0, 32'hFFFE);
    rxf(16'h0010, 1'b1, 1'b1, 1'b0);
    quiet;
    rdc("wide high latched", 16'h40C4, 32'h1);
    rdc("low after latch", 16'h40C0, 32'h10);
    rdc("wide packets", 16'h40D0, 32'h10003);
    $display("test wide octets done");
    wr(`STATS_CONTROL_OFS, 32'h0, r);
    rxf(16'h0020, 1'b0, 1'b1, 1'b0);
    txf(16'h0040, 1'b0, 1'b0);
    quiet;
    chk("enables off", {30'h0, tx_en, rx_en}, 32'h0);
    rdc("fragments off", 16'h40A8, 32'h0);
    rdc("rx packets off", 16'h40D0, 32'h0);
    rdc("tx packets off", 16'h40D4, 32'h0);
    rdc("bin 64 off", 16'h40D8, 32'h0);
    $display("test disabled counting done");
    complete_run;
  end
endmodule
